// File: hdl/uft_pkg.sv
// constants and types for the uplink frame and power timing block
package uft_pkg;
  // chip clock: one enable per chip derived from a 20 MHz clock is out of scope; one tick = one chip
  localparam int unsigned CLK_HZ           = 20_000_000;
  localparam int unsigned CHIP_W           = 16;
  localparam int unsigned CHIPS_PER_SLOT   = 2560;
  localparam int unsigned SLOTS_PER_FRAME  = 16;
  localparam int unsigned FRAME_CHIPS      = CHIPS_PER_SLOT * SLOTS_PER_FRAME;
  localparam int unsigned OFFSET_STEP      = 256;
  localparam int unsigned UL_DELAY_US      = 250;
  localparam int unsigned TPC_DELAY_US     = 125;
  localparam int unsigned UL_DELAY_CYC     = (UL_DELAY_US * (CLK_HZ / 1_000_000));
  localparam int unsigned TPC_DELAY_CYC    = (TPC_DELAY_US * (CLK_HZ / 1_000_000));
  localparam logic [CHIP_W-1:0] FRAME_LAST = CHIP_W'(FRAME_CHIPS - 1);
  localparam logic [CHIP_W-1:0] SLOT_LAST  = CHIP_W'(CHIPS_PER_SLOT - 1);
  localparam logic [CHIP_W-1:0] PILOT_LEN  = 16'h0100;
  localparam logic [CHIP_W-1:0] RST_ZERO   = 16'h0000;
  localparam logic [7:0]        SIR_RST    = 8'h00;

  typedef enum logic [1:0] {
    UFT_IDLE  = 2'b00,
    UFT_ALIGN = 2'b01,
    UFT_RUN   = 2'b11
  } uft_state_t;

  function automatic logic [CHIP_W-1:0] uft_wrap(input logic [CHIP_W-1:0] v,
                                                  input logic [CHIP_W-1:0] last);
    return (v == last) ? RST_ZERO : v + 16'h0001;
  endfunction
endpackage

// File: hdl/uft_sync.sv
// two flip-flop synchroniser for a pin level
`timescale 1ns/1ns
module uft_sync (
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  input  wire logic i_d,
  output logic      o_q
);
  logic meta;
  logic next_meta;
  logic next_q;

  always_comb begin
    next_meta = i_d;
    next_q    = meta;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta <= 1'b0;
      o_q  <= 1'b0;
    end else begin
      meta <= next_meta;
      o_q  <= next_q;
    end
  end
endmodule // uft_sync

// File: hdl/uft_top.sv
// uplink frame alignment, timing-difference measurement and power-control timing
//
// Function
// (R1) base station steps each downlink frame offset in 256-chip units.
// (R2) uplink frame starts fixed offset after earliest downlink path frame boundary.
// (R3) uplink scrambling generator restarts on every uplink frame boundary.
// (R4) measure target common-channel frame timing minus earliest dedicated path timing.
// (R5) target cell sets its downlink offset from the reported difference.
// (R6) uplink frame lags downlink frame by 250 microseconds at the antenna.
// (R7) apply received power command at first uplink pilot start after reception.
// (R8) base station applies uplink power command at a later downlink pilot.
// (R9) uplink power command derives from downlink signal-to-interference measurement.
// (R10) uplink command field starts 125 microseconds after downlink pilot end.
// (R11) base station derives its commands from uplink signal-to-interference measurement.
// (R12) base station may defer a late power change to the next slot.
// (R13) base station may set downlink offsets per channel individually.
// (R14) all offsets and field positions come from chip counters on the downlink boundary.
`timescale 1ns/1ns
module uft_top (
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_dl_frame,
  input  wire logic        i_tgt_frame,
  input  wire logic        i_tpc_valid,
  input  wire logic        i_tpc_up,
  input  wire logic [7:0]  i_sir,
  input  wire logic [7:0]  i_sir_target,
  output logic             o_ul_frame,
  output logic             o_scr_reset,
  output logic             o_ul_pilot,
  output logic             o_tpc_field,
  output logic             o_tpc_cmd,
  output logic             o_pwr_step,
  output logic             o_pwr_up,
  output logic [15:0]      o_tdiff,
  output logic             o_tdiff_valid
);
  localparam logic [15:0] UL_OFF  = 16'(uft_pkg::UL_DELAY_CYC);
  // the field lands in the slot after its pilot, so its chip position wraps modulo the slot;
  // one chip is taken off because the field pulse is registered
  localparam logic [15:0] TPC_AT  =
    16'((uft_pkg::PILOT_LEN + uft_pkg::TPC_DELAY_CYC - 1) % uft_pkg::CHIPS_PER_SLOT);

  logic dl_s, tgt_s, dl_d, tgt_d;
  logic dl_edge, tgt_edge;

  uft_sync u_sync_dl (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_d      (i_dl_frame),
    .o_q      (dl_s)
  );
  uft_sync u_sync_tgt (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_d      (i_tgt_frame),
    .o_q      (tgt_s)
  );

  assign dl_edge  = dl_s & ~dl_d;
  assign tgt_edge = tgt_s & ~tgt_d;

  uft_pkg::uft_state_t state, next_state;
  logic [15:0] dl_cnt, next_dl_cnt;
  logic [15:0] ul_cnt, next_ul_cnt;
  logic [15:0] slot_cnt, next_slot_cnt;
  logic        pend, next_pend;
  logic        pend_up, next_pend_up;
  logic        ul_frame, next_ul_frame;
  logic        ul_pilot, next_ul_pilot;
  logic        tpc_field, next_tpc_field;
  logic        tpc_cmd, next_tpc_cmd;
  logic        pwr_step, next_pwr_step;
  logic        pwr_up, next_pwr_up;
  logic [15:0] tdiff, next_tdiff;
  logic        tdv, next_tdv;
  logic        ul_start;

  // uplink frame boundary sits a fixed chip count after the downlink boundary
  assign ul_start = (state == uft_pkg::UFT_RUN) && (dl_cnt == UL_OFF); // [R2] [R6] [R14]

  always_comb begin
    next_state     = state;
    next_dl_cnt    = uft_pkg::uft_wrap(dl_cnt, uft_pkg::FRAME_LAST); // [R14]
    next_ul_cnt    = uft_pkg::uft_wrap(ul_cnt, uft_pkg::SLOT_LAST);
    next_slot_cnt  = uft_pkg::uft_wrap(slot_cnt, uft_pkg::SLOT_LAST);
    next_pend      = pend;
    next_pend_up   = pend_up;
    next_ul_frame  = ul_start;
    next_pwr_step  = 1'b0;
    next_pwr_up    = pwr_up;
    next_tdiff     = tdiff;
    next_tdv       = 1'b0;
    next_tpc_cmd   = tpc_cmd;
    case (state)
      uft_pkg::UFT_IDLE: begin
        if (dl_edge) begin
          next_state = uft_pkg::UFT_ALIGN;
        end
      end
      uft_pkg::UFT_ALIGN: begin
        next_state = uft_pkg::UFT_RUN;
      end
      uft_pkg::UFT_RUN: begin
      end
      default: begin
        next_state = uft_pkg::UFT_IDLE;
      end
    endcase
    // earliest path boundary re-references the frame and slot counters; the uplink counter restarts at ul_start
    if (dl_edge) begin
      next_dl_cnt   = 16'h0001;
      next_slot_cnt = 16'h0001;
    end
    if (ul_start) begin
      next_ul_cnt = uft_pkg::RST_ZERO;
    end
    // difference taken modulo the frame, so an early target edge reads as a large value
    if (tgt_edge && state == uft_pkg::UFT_RUN) begin
      next_tdiff = dl_cnt; // [R4]
      next_tdv   = 1'b1;
    end
    // sir compare latched at pilot end so the command is ready for its field
    if (slot_cnt == uft_pkg::PILOT_LEN) begin
      next_tpc_cmd = (i_sir < i_sir_target); // [R9]
    end
    // a command arriving on the pilot start itself waits for the next pilot
    if (i_tpc_valid) begin
      next_pend    = 1'b1;
      next_pend_up = i_tpc_up;
    // decided one chip early so the registered step lands on the first pilot chip
    end else if (pend && state == uft_pkg::UFT_RUN && next_ul_cnt == uft_pkg::RST_ZERO) begin
      next_pend     = 1'b0; // [R7]
      next_pwr_step = 1'b1;
      next_pwr_up   = pend_up;
    end
    next_ul_pilot  = (state == uft_pkg::UFT_RUN) && (next_ul_cnt < uft_pkg::PILOT_LEN);
    next_tpc_field = (state == uft_pkg::UFT_RUN) &&
                     (slot_cnt == TPC_AT); // [R10]
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state     <= uft_pkg::UFT_IDLE;
      dl_d      <= 1'b0;
      tgt_d     <= 1'b0;
      dl_cnt    <= uft_pkg::RST_ZERO;
      ul_cnt    <= uft_pkg::RST_ZERO;
      slot_cnt  <= uft_pkg::RST_ZERO;
      pend      <= 1'b0;
      pend_up   <= 1'b0;
      ul_frame  <= 1'b0;
      ul_pilot  <= 1'b0;
      tpc_field <= 1'b0;
      tpc_cmd   <= 1'b0;
      pwr_step  <= 1'b0;
      pwr_up    <= 1'b0;
      tdiff     <= uft_pkg::RST_ZERO;
      tdv       <= 1'b0;
    end else begin
      state     <= next_state;
      dl_d      <= dl_s;
      tgt_d     <= tgt_s;
      dl_cnt    <= next_dl_cnt;
      ul_cnt    <= next_ul_cnt;
      slot_cnt  <= next_slot_cnt;
      pend      <= next_pend;
      pend_up   <= next_pend_up;
      ul_frame  <= next_ul_frame;
      ul_pilot  <= next_ul_pilot;
      tpc_field <= next_tpc_field;
      tpc_cmd   <= next_tpc_cmd;
      pwr_step  <= next_pwr_step;
      pwr_up    <= next_pwr_up;
      tdiff     <= next_tdiff;
      tdv       <= next_tdv;
    end
  end

  assign o_ul_frame    = ul_frame;
  assign o_scr_reset   = ul_frame; // [R3]
  assign o_ul_pilot    = ul_pilot;
  assign o_tpc_field   = tpc_field;
  assign o_tpc_cmd     = tpc_cmd;
  assign o_pwr_step    = pwr_step;
  assign o_pwr_up      = pwr_up;
  assign o_tdiff       = tdiff;
  assign o_tdiff_valid = tdv;

  sequence s_ul_start;
    state == uft_pkg::UFT_RUN && dl_cnt == UL_OFF;
  endsequence

  a_ul_frame_pos: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [R2]
    s_ul_start |=> o_ul_frame)
    else $error("uplink frame not at offset");
  a_ul_frame_only: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [R6]
    o_ul_frame |-> $past(dl_cnt) == UL_OFF)
    else $error("uplink frame at wrong chip");
  a_scr_align: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [R3]
    o_scr_reset |-> ul_cnt == uft_pkg::RST_ZERO)
    else $error("scrambler reset not aligned");
  a_pilot_after: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [R3]
    o_ul_frame |-> o_ul_pilot)
    else $error("pilot not at frame start");
  a_pwr_pending: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [R7]
    o_pwr_step |-> $past(pend) && o_ul_pilot && ul_cnt == uft_pkg::RST_ZERO)
    else $error("power step without pilot start");
  a_pwr_bound: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [R7]
    (pend && !i_tpc_valid && state == uft_pkg::UFT_RUN && next_ul_cnt == uft_pkg::RST_ZERO)
    |=> o_pwr_step)
    else $error("power step missed");
  a_tpc_pos: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [R10]
    o_tpc_field |-> $past(slot_cnt) == TPC_AT)
    else $error("command field misplaced");
  a_tdiff_cap: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [R4]
    (tgt_edge && state == uft_pkg::UFT_RUN) |=> o_tdiff_valid && o_tdiff == $past(dl_cnt))
    else $error("timing difference not captured");
  a_sir_cmd: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [R9]
    (slot_cnt == uft_pkg::PILOT_LEN) |=> o_tpc_cmd == ($past(i_sir) < $past(i_sir_target)))
    else $error("command not from sir");
  a_dl_ref: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [R14]
    dl_edge |=> dl_cnt == 16'h0001)
    else $error("counter not referenced");
endmodule // uft_top

// File: sim/uft_bs.sv
// base station model: downlink boundaries and downlink power commands
`timescale 1ns/1ns
module uft_bs (
  input  wire logic i_clk,
  input  wire logic i_field,
  input  wire logic i_cmd,
  output logic      o_dl,
  output logic      o_tgt,
  output logic      o_valid,
  output logic      o_up,
  output logic      o_pwr
);
  logic run;
  logic held;
  int   chip;
  initial begin
    o_dl = 1'b0;
    o_tgt = 1'b0;
    o_valid = 1'b0;
    o_up = 1'b0;
    o_pwr = 1'b0;
    run = 1'b0;
    held = 1'b0;
    chip = 0;
  end
  // uplink command waits for a later downlink pilot start, never applied mid-slot
  always @(posedge i_clk) begin
    if (i_field) held <= i_cmd;
    if (run && chip == 0) o_pwr <= held;
    chip <= (!run || chip == uft_pkg::CHIPS_PER_SLOT - 1) ? 0 : chip + 1;
  end
  // held three cycles so the two-stage synchroniser cannot miss it
  task automatic boundary(input logic target);
    if (target) o_tgt = 1'b1;
    else o_dl = 1'b1;
    run = run | ~target;
    repeat (3) @(negedge i_clk);
    o_dl = 1'b0;
    o_tgt = 1'b0;
  endtask
  // commands from the caller's dirs pattern; n pulses held back to back
  task automatic pulse(input int n, input logic [1:0] dirs);
    for (int i = 0; i < n; i++) begin
      o_valid = 1'b1;
      o_up = dirs[i];
      @(negedge i_clk);
    end
    o_valid = 1'b0;
  endtask
endmodule // uft_bs

// File: sim/uft_top_bench.sv
// bench for the uplink frame and power timing block
`timescale 1ns/1ns
module uft_top_bench;
  logic        clk, arst_n, dl, tgt, tv, tu, pp;
  logic        ul_frame, scr, pilot, tf, cmd, step, up, tval, bs_pwr;
  logic [7:0]  sir, sir_tgt;
  logic [15:0] tdiff;
  int          fail_count, checks, cyc, k, t, n;
  // rows: measured level, target level, expected command
  logic [16:0] rows [0:3] = '{{8'h0a, 8'h14, 1'h1}, {8'h14, 8'h0a, 1'h0},
                              {8'h0f, 8'h0f, 1'h0}, {8'h00, 8'hff, 1'h1}};
  uft_bs bs (.i_clk(clk), .i_field(tf), .i_cmd(cmd), .o_dl(dl), .o_tgt(tgt), .o_valid(tv),
    .o_up(tu), .o_pwr(bs_pwr));
  uft_top dut (.i_clk(clk), .i_arst_n(arst_n), .i_dl_frame(dl), .i_tgt_frame(tgt),
    .i_tpc_valid(tv), .i_tpc_up(tu), .i_sir(sir), .i_sir_target(sir_tgt),
    .o_ul_frame(ul_frame), .o_scr_reset(scr), .o_ul_pilot(pilot), .o_tpc_field(tf),
    .o_tpc_cmd(cmd), .o_pwr_step(step), .o_pwr_up(up), .o_tdiff(tdiff),
    .o_tdiff_valid(tval));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // whole run is near 33000 cycles
  initial cyc = 0;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask
  function automatic logic sel(input int s);
    case (s)
      0: return ul_frame;
      1: return tf;
      2: return step;
      default: return tval;
    endcase
  endfunction
  // pp keeps the pilot level one cycle before the event
  task automatic wait_on(input int s);
    n = 0;
    do begin
      pp = pilot;
      @(negedge clk);
      n++;
    end while (sel(s) !== 1'b1 && n < 6000);
    if (n >= 6000) chk("wait", 16'h0001, 16'h0000);
  endtask
  initial begin
    arst_n = 1'b0;
    sir = 8'h00;
    sir_tgt = 8'h00;
    fail_count = 0;
    checks = 0;
    repeat (6) @(negedge clk);
    chk("reset", 16'h0000, {ul_frame, scr, pilot, tf, cmd, step, up, tval, tdiff[7:0]});
    $display("test reset done");
    arst_n = 1'b1;
    @(negedge clk);
    k = cyc;
    bs.boundary(1'b0);
    wait_on(1);
    // two synchroniser stages lie between the pin and the chip counter
    chk("field", 16'((uft_pkg::PILOT_LEN + uft_pkg::TPC_DELAY_CYC) % uft_pkg::CHIPS_PER_SLOT + 2),
      16'(cyc - k));
    wait_on(0);
    // the frame pulse is registered one chip after the offset count
    chk("frame", 16'(uft_pkg::UL_DELAY_CYC + 3), 16'(cyc - k));
    chk("scrambler", 16'h0001, 16'(scr));
    n = 0;
    while (pilot === 1'b1 && n < 300) begin
      n++;
      @(negedge clk);
    end
    chk("pilot", uft_pkg::PILOT_LEN, 16'(n));
    $display("test frame timing done");
    for (int i = 0; i < 4; i++) begin
      sir = rows[i][16:9];
      sir_tgt = rows[i][8:1];
      wait_on(1);
      wait_on(1);
      chk("command", 16'(rows[i][0]), 16'(cmd));
    end
    $display("test command table done");
    // third case: a second command overwrites the first
    for (int i = 0; i < 3; i++) begin
      bs.pulse(i == 2 ? 2 : 1, i == 1 ? 2'b00 : 2'b01);
      wait_on(2);
      chk("step dir", 16'(i == 0), 16'(up));
      chk("step at pilot", 16'h0001, 16'({pp, pilot} == 2'b01));
    end
    chk("base power", 16'(rows[3][0]), 16'(bs_pwr));
    $display("test power steps done");
    for (int i = 1; i < 3; i++) begin
      repeat (256 * 3 * i) @(negedge clk);
      t = cyc;
      // the valid pulse stands exactly as the three-cycle pin hold ends
      bs.boundary(1'b1);
      chk("tdiff valid", 16'h0001, 16'(tval));
      chk("tdiff", 16'((t - k) % uft_pkg::FRAME_CHIPS), tdiff);
    end
    $display("test timing difference done");
    conclude();
  end
endmodule // uft_top_bench
